// file: verilog/dcfs_pkg.sv
// Shared constants and state encodings for the demand curve and fault supervisor
package dcfs_pkg;
    // Demand encoding
    localparam int DEMAND_W = 9;
    localparam logic [8:0] DEMAND_MAX = 9'h1FF;
    localparam logic [8:0] DEMAND_STOP = 9'h0FF;
    localparam logic [8:0] DEMAND_ZERO = 9'h000;
    // Corner storage: locations 32..63, input in upper nine bits, output in lower nine
    localparam int CORNER_W = 18;
    localparam int CORNER_COUNT = 32;
    localparam logic [5:0] CORNER_BASE = 6'h20;
    localparam logic [4:0] IDX_LAST = 5'h1F;
    localparam int IN_MSB = 17;
    localparam int IN_LSB = 9;
    localparam int OUT_MSB = 8;
    localparam int OUT_LSB = 0;
    // Control modes
    localparam logic [1:0] MODE_OPEN_LOOP = 2'h0;
    // Clock and slow tick
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
    // Hold times
    localparam int MS_PER_S = 1000;
    localparam int STALL_HOLD_SHORT_S = 5;
    localparam int STALL_HOLD_LONG_S = 10;
    localparam int OC_HOLD_S = 5;
    localparam logic [13:0] STALL_HOLD_SHORT_MS = 14'(STALL_HOLD_SHORT_S * MS_PER_S);
    localparam logic [13:0] STALL_HOLD_LONG_MS = 14'(STALL_HOLD_LONG_S * MS_PER_S);
    localparam logic [13:0] OC_HOLD_MS = 14'(OC_HOLD_S * MS_PER_S);
    // Overcurrent blanking and filter, base time doubled per select step
    localparam int BLANK_BASE_NS = 250;
    localparam int FILTER_BASE_NS = 500;
    localparam logic [7:0] BLANK_BASE_CYC = 8'((BLANK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] FILTER_BASE_CYC = 8'((FILTER_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Restart attempt limits
    localparam logic [3:0] RETRY_LIMIT_0 = 4'h3;
    localparam logic [3:0] RETRY_LIMIT_1 = 4'h5;
    localparam logic [3:0] RETRY_LIMIT_2 = 4'hA;
    localparam logic [1:0] RETRY_SEL_ALWAYS = 2'h3;
    // Supervisor states
    typedef enum logic [4:0] {
        SUP_RUN = 5'h01,
        SUP_STALL_HOLD = 5'h02,
        SUP_STALL_LOCK = 5'h04,
        SUP_OC_HOLD = 5'h08,
        SUP_OC_WAIT = 5'h10
    } dcfs_sup_e;
    // Curve walk states
    typedef enum logic [2:0] {
        XF_IDLE = 3'h1,
        XF_WAIT = 3'h2,
        XF_EVAL = 3'h4
    } dcfs_xf_e;
endpackage

// file: verilog/dcfs_curve_mem.sv
// Corner point storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module dcfs_curve_mem (
    // Clock
    input wire logic sys_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [17:0] wr_data,
    // Read port
    input wire logic [4:0] rd_addr,
    output logic [17:0] rd_data
);
    logic [17:0] mem [0:dcfs_pkg::CORNER_COUNT-1];

    // Read returns the old word on a same-address write
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// file: verilog/dcfs_top.sv
// Demand curve transformer and motor fault supervisor
// Behaviour
// - Nine-bit demand maps to nine-bit demand always
// - Open loop output sets duty directly
// - Closed loop output scales loop range maximum
// - Corners from locations 32-63, interpolate between
// - Corner word: input upper, output lower
// - Stop at input 511; 32 corners max
// - Descending corner gives hysteresis step
// - Transformer disabled means output equals input
// - Bidirectional: 511 forward, 255 stop, 0 reverse
// - Motor constant estimate above limit means stall
// - Phase advance at ramp end checks stall
// - Stall coasts, restarts after 5/10 s
// - No-hold select skips the stall hold
// - Retry limit 3/5/10/always; zero demand clears
// - Overcurrent first: all switches off, fault state
// - Recovery mode: zero demand, 5 s, or at once
// - Blank overcurrent after each gate turn-on
// - Overcurrent must persist through filter time
// - Undervoltage disables outputs, asserts fault pin
// - Supply overvoltage coasts when enabled, else ignored
// - Zero post-curve demand flagged, no action
// - Overtemperature coasts, restarts with demand present
`timescale 1ns/100ps
`default_nettype none
module dcfs_top #(
    parameter int TICK_CYCLES = dcfs_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Demand path
    input wire logic [8:0] demand_in,
    input wire logic curve_enable,
    input wire logic bidir_enable,
    input wire logic [1:0] control_mode,
    input wire logic [15:0] loop_range_max,
    // Corner storage write
    input wire logic curve_wr_en,
    input wire logic [5:0] curve_wr_loc,
    input wire logic [17:0] curve_wr_data,
    // Stall detection
    input wire logic bemf_lock_enable,
    input wire logic [15:0] motor_constant_estimate,
    input wire logic [15:0] motor_constant_limit,
    input wire logic startup_lock_enable,
    input wire logic ramp_end,
    input wire logic [7:0] phase_advance,
    input wire logic [7:0] angle_error_limit,
    input wire logic stall_hold_long_select,
    input wire logic stall_no_hold_select,
    input wire logic [1:0] stall_retry_select,
    // Bridge and overcurrent
    input wire logic [5:0] gate_cmd,
    input wire logic [5:0] drain_over,
    input wire logic overcurrent_recovery_mode,
    input wire logic overcurrent_no_hold_select,
    input wire logic [1:0] overcurrent_blank_time_select,
    input wire logic [1:0] overcurrent_filter_time_select,
    input wire logic [1:0] drain_voltage_threshold_select,
    // Supplies and temperature
    input wire logic charge_pump_uv,
    input wire logic low_side_reg_uv,
    input wire logic motor_supply_over,
    input wire logic supply_overvoltage_protect_enable,
    input wire logic over_temp,
    // Drive outputs
    output logic [5:0] gate_drive_ff,
    output logic [1:0] drain_threshold_ff,
    output logic [8:0] demand_out_ff,
    output logic [8:0] duty_ff,
    output logic [15:0] setpoint_ff,
    output logic reverse_ff,
    // Status outputs
    output logic fault_n_ff,
    output logic stall_ff,
    output logic lock_ff,
    output logic overcurrent_ff,
    output logic system_fault_ff,
    output logic overvoltage_ff,
    output logic overtemp_ff,
    output logic zero_demand_ff
);
    typedef struct packed {
        dcfs_pkg::dcfs_xf_e xf_st;
        logic [4:0] idx;
        logic first;
        logic found;
        logic rising;
        logic [8:0] dem;
        logic [8:0] prev_in;
        logic [8:0] prev_out;
        logic [8:0] cand;
        logic [8:0] demand_out;
        dcfs_pkg::dcfs_sup_e sup_st;
        logic [3:0] attempts;
        logic [13:0] hold_ms;
        logic [15:0] tick_cnt;
        logic ot_wait;
        logic [5:0] gate_prev;
        logic [5:0][7:0] blank;
        logic [5:0][7:0] fil;
        logic [5:0] gate_drive;
        logic [1:0] vds_sel;
        logic [8:0] duty;
        logic [15:0] setpoint;
        logic reverse;
        logic fault_n;
        logic stall;
        logic lock;
        logic oc;
        logic sys_fault;
        logic ov;
        logic ot;
        logic zero;
    } dcfs_state_s;

    dcfs_state_s s_ff;
    dcfs_state_s nxt_s;
    logic [17:0] rd_data;
    logic [8:0] c_in;
    logic [8:0] c_out;
    logic [9:0] span;
    logic [9:0] dx;
    logic signed [9:0] dy;
    logic signed [19:0] prod;
    logic signed [19:0] quo;
    logic [9:0] sum10;
    logic [8:0] interp;
    logic [8:0] mag;
    logic [24:0] sp_prod;
    logic [24:0] sp_quo;
    logic [7:0] blank_cyc;
    logic [7:0] filt_cyc;
    logic [5:0] oc_hit;
    logic [3:0] retry_limit;
    logic tick;
    logic zero_dem;
    logic sys_uv;
    logic ov_stop;
    logic stall_evt;
    logic oc_evt;
    logic limit_hit;

    // Corner words live in their own memory; locations below the base are not curve data
    dcfs_curve_mem u_mem (
        .sys_clk (sys_clk),
        .wr_en (curve_wr_en && (curve_wr_loc >= dcfs_pkg::CORNER_BASE)),
        .wr_addr (curve_wr_loc[4:0]),
        .wr_data (curve_wr_data),
        .rd_addr (s_ff.idx),
        .rd_data (rd_data)
    );

    // Segment interpolation, signed so a falling segment truncates toward zero
    always_comb
    begin
        c_in = rd_data[dcfs_pkg::IN_MSB:dcfs_pkg::IN_LSB];
        c_out = rd_data[dcfs_pkg::OUT_MSB:dcfs_pkg::OUT_LSB];
        span = {1'b0, c_in} - {1'b0, s_ff.prev_in};
        dx = {1'b0, s_ff.dem} - {1'b0, s_ff.prev_in};
        dy = $signed({1'b0, c_out}) - $signed({1'b0, s_ff.prev_out});
        prod = dy * $signed(dx);
        quo = (span == 10'h000) ? 20'sh00000 : prod / $signed({10'h000, span});
        sum10 = 10'($signed({1'b0, s_ff.prev_out}) + $signed(quo[9:0]));
        interp = sum10[8:0];
    end

    // Drive magnitude and scaling of the transformed demand
    always_comb
    begin
        if (!bidir_enable)
        begin
            mag = s_ff.demand_out;
        end
        else if (s_ff.demand_out[8])
        begin
            mag = {s_ff.demand_out[7:0], 1'b1};
        end
        else
        begin
            mag = {~s_ff.demand_out[7:0], 1'b0};
        end
        sp_prod = 25'(mag) * 25'(loop_range_max);
        sp_quo = sp_prod / 25'(dcfs_pkg::DEMAND_MAX);
    end

    // Fault causes and retry limit decode
    always_comb
    begin
        tick = (s_ff.tick_cnt == 16'(TICK_CYCLES - 1));
        zero_dem = (s_ff.demand_out == dcfs_pkg::DEMAND_ZERO);
        sys_uv = charge_pump_uv || low_side_reg_uv;
        ov_stop = supply_overvoltage_protect_enable && motor_supply_over;
        stall_evt = (s_ff.sup_st == dcfs_pkg::SUP_RUN) &&
            ((bemf_lock_enable && (motor_constant_estimate > motor_constant_limit)) ||
            (startup_lock_enable && ramp_end && (phase_advance > angle_error_limit)));
        case (stall_retry_select)
            2'h0: retry_limit = dcfs_pkg::RETRY_LIMIT_0;
            2'h1: retry_limit = dcfs_pkg::RETRY_LIMIT_1;
            2'h2: retry_limit = dcfs_pkg::RETRY_LIMIT_2;
            default: retry_limit = dcfs_pkg::RETRY_LIMIT_2;
        endcase
        limit_hit = (stall_retry_select != dcfs_pkg::RETRY_SEL_ALWAYS) &&
            (s_ff.attempts >= retry_limit);
        blank_cyc = 8'(dcfs_pkg::BLANK_BASE_CYC << overcurrent_blank_time_select);
        filt_cyc = 8'(dcfs_pkg::FILTER_BASE_CYC << overcurrent_filter_time_select);
    end

    // Next state of the whole block
    always_comb
    begin
        nxt_s = s_ff;
        oc_hit = 6'h00;
        nxt_s.tick_cnt = tick ? 16'h0000 : s_ff.tick_cnt + 16'h0001;

        // Curve walk: two cycles per corner because the memory read is registered
        case (s_ff.xf_st)
            dcfs_pkg::XF_IDLE:
            begin
                if (!curve_enable)
                begin
                    nxt_s.demand_out = demand_in;
                    nxt_s.dem = demand_in;
                end
                else
                begin
                    if (demand_in != s_ff.dem)
                    begin
                        nxt_s.rising = (demand_in > s_ff.dem);
                    end
                    nxt_s.dem = demand_in;
                    nxt_s.idx = 5'h00;
                    nxt_s.first = 1'b1;
                    nxt_s.found = 1'b0;
                    nxt_s.xf_st = dcfs_pkg::XF_WAIT;
                end
            end
            dcfs_pkg::XF_WAIT:
            begin
                nxt_s.xf_st = dcfs_pkg::XF_EVAL;
            end
            dcfs_pkg::XF_EVAL:
            begin
                if (s_ff.first)
                begin
                    if (s_ff.dem <= c_in)
                    begin
                        nxt_s.found = 1'b1;
                        nxt_s.cand = c_out;
                    end
                end
                else if (c_in >= s_ff.prev_in)
                begin
                    if (!s_ff.found && (s_ff.dem <= c_in) && (s_ff.dem >= s_ff.prev_in))
                    begin
                        nxt_s.found = 1'b1;
                        nxt_s.cand = interp;
                    end
                end
                else if ((s_ff.dem >= c_in) && (s_ff.dem <= s_ff.prev_in))
                begin
                    // A band overrides any earlier segment match
                    nxt_s.found = 1'b1;
                    if (s_ff.rising)
                    begin
                        nxt_s.cand = (s_ff.dem < s_ff.prev_in) ? s_ff.prev_out : c_out;
                    end
                    else
                    begin
                        nxt_s.cand = (s_ff.dem > c_in) ? c_out : s_ff.prev_out;
                    end
                end
                nxt_s.prev_in = c_in;
                nxt_s.prev_out = c_out;
                nxt_s.first = 1'b0;
                if ((c_in == dcfs_pkg::DEMAND_MAX) || (s_ff.idx == dcfs_pkg::IDX_LAST))
                begin
                    nxt_s.demand_out = nxt_s.found ? nxt_s.cand : c_out;
                    nxt_s.xf_st = dcfs_pkg::XF_IDLE;
                end
                else
                begin
                    nxt_s.idx = s_ff.idx + 5'h01;
                    nxt_s.xf_st = dcfs_pkg::XF_WAIT;
                end
            end
            default:
            begin
                nxt_s.xf_st = dcfs_pkg::XF_IDLE;
            end
        endcase

        // Per-switch blanking after turn-on, then a persistence filter
        nxt_s.gate_prev = s_ff.gate_drive;
        for (int i = 0; i < 6; i++)
        begin
            if (!s_ff.gate_drive[i])
            begin
                nxt_s.blank[i] = 8'h00;
                nxt_s.fil[i] = 8'h00;
            end
            else if (!s_ff.gate_prev[i])
            begin
                nxt_s.blank[i] = blank_cyc;
                nxt_s.fil[i] = 8'h00;
            end
            else if (s_ff.blank[i] != 8'h00)
            begin
                nxt_s.blank[i] = s_ff.blank[i] - 8'h01;
                nxt_s.fil[i] = 8'h00;
            end
            else if (drain_over[i])
            begin
                nxt_s.fil[i] = s_ff.fil[i] + 8'h01;
                oc_hit[i] = (s_ff.fil[i] == filt_cyc - 8'h01);
            end
            else
            begin
                nxt_s.fil[i] = 8'h00;
            end
        end
        oc_evt = |oc_hit;

        // Zero demand clears the retry count in any state, except that a stall counted in the same cycle wins
        if (zero_dem)
        begin
            nxt_s.attempts = 4'h0;
        end

        // Supervisor: overcurrent is checked ahead of stall
        case (s_ff.sup_st)
            dcfs_pkg::SUP_RUN:
            begin
                nxt_s.hold_ms = 14'h0000;
                if (oc_evt)
                begin
                    if (!overcurrent_recovery_mode)
                    begin
                        nxt_s.sup_st = dcfs_pkg::SUP_OC_WAIT;
                    end
                    else if (!overcurrent_no_hold_select)
                    begin
                        nxt_s.sup_st = dcfs_pkg::SUP_OC_HOLD;
                    end
                end
                else if (stall_evt)
                begin
                    if (limit_hit)
                    begin
                        nxt_s.sup_st = dcfs_pkg::SUP_STALL_LOCK;
                    end
                    else
                    begin
                        nxt_s.attempts = s_ff.attempts + 4'h1;
                        if (!stall_no_hold_select)
                        begin
                            nxt_s.sup_st = dcfs_pkg::SUP_STALL_HOLD;
                        end
                    end
                end
            end
            dcfs_pkg::SUP_STALL_HOLD:
            begin
                if (tick)
                begin
                    nxt_s.hold_ms = s_ff.hold_ms + 14'h0001;
                    if (s_ff.hold_ms == (stall_hold_long_select ? dcfs_pkg::STALL_HOLD_LONG_MS :
                        dcfs_pkg::STALL_HOLD_SHORT_MS) - 14'h0001)
                    begin
                        nxt_s.sup_st = dcfs_pkg::SUP_RUN;
                    end
                end
            end
            dcfs_pkg::SUP_OC_HOLD:
            begin
                if (tick)
                begin
                    nxt_s.hold_ms = s_ff.hold_ms + 14'h0001;
                    if (s_ff.hold_ms == dcfs_pkg::OC_HOLD_MS - 14'h0001)
                    begin
                        nxt_s.sup_st = dcfs_pkg::SUP_RUN;
                    end
                end
            end
            dcfs_pkg::SUP_STALL_LOCK, dcfs_pkg::SUP_OC_WAIT:
            begin
                if (zero_dem)
                begin
                    nxt_s.sup_st = dcfs_pkg::SUP_RUN;
                end
            end
            default:
            begin
                nxt_s.sup_st = dcfs_pkg::SUP_RUN;
            end
        endcase

        // Overtemperature waits for cool-down and demand; set wins over clear
        if (over_temp)
        begin
            nxt_s.ot_wait = 1'b1;
        end
        else if (!zero_dem)
        begin
            nxt_s.ot_wait = 1'b0;
        end

        // Gate drive: any inhibit coasts the motor by opening all switches
        if ((nxt_s.sup_st == dcfs_pkg::SUP_RUN) && !oc_evt && !sys_uv && !ov_stop &&
            !over_temp && !s_ff.ot_wait)
        begin
            nxt_s.gate_drive = gate_cmd;
        end
        else
        begin
            nxt_s.gate_drive = 6'h00;
        end
        nxt_s.vds_sel = drain_voltage_threshold_select;

        // Demand presentation for the control loop
        nxt_s.reverse = bidir_enable && !s_ff.demand_out[8] &&
            (s_ff.demand_out != dcfs_pkg::DEMAND_STOP);
        if (control_mode == dcfs_pkg::MODE_OPEN_LOOP)
        begin
            nxt_s.duty = mag;
            nxt_s.setpoint = 16'h0000;
        end
        else
        begin
            nxt_s.duty = 9'h000;
            nxt_s.setpoint = sp_quo[15:0];
        end

        // Status flags
        nxt_s.zero = zero_dem;
        nxt_s.sys_fault = sys_uv;
        nxt_s.ov = ov_stop;
        nxt_s.ot = nxt_s.ot_wait;
        nxt_s.oc = (nxt_s.sup_st == dcfs_pkg::SUP_OC_HOLD) ||
            (nxt_s.sup_st == dcfs_pkg::SUP_OC_WAIT) || oc_evt;
        nxt_s.stall = (nxt_s.sup_st == dcfs_pkg::SUP_STALL_HOLD) || stall_evt;
        nxt_s.lock = (nxt_s.sup_st == dcfs_pkg::SUP_STALL_LOCK);
        nxt_s.fault_n = !(sys_uv || ov_stop || nxt_s.oc);
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_ff <= '0;
            s_ff.xf_st <= dcfs_pkg::XF_IDLE;
            s_ff.sup_st <= dcfs_pkg::SUP_RUN;
            s_ff.fault_n <= 1'b1;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign gate_drive_ff = s_ff.gate_drive;
    assign drain_threshold_ff = s_ff.vds_sel;
    assign demand_out_ff = s_ff.demand_out;
    assign duty_ff = s_ff.duty;
    assign setpoint_ff = s_ff.setpoint;
    assign reverse_ff = s_ff.reverse;
    assign fault_n_ff = s_ff.fault_n;
    assign stall_ff = s_ff.stall;
    assign lock_ff = s_ff.lock;
    assign overcurrent_ff = s_ff.oc;
    assign system_fault_ff = s_ff.sys_fault;
    assign overvoltage_ff = s_ff.ov;
    assign overtemp_ff = s_ff.ot;
    assign zero_demand_ff = s_ff.zero;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_identity_map:
    assert property ((s_ff.xf_st == dcfs_pkg::XF_IDLE) && !curve_enable |=>
        demand_out_ff == $past(demand_in)) else $error("identity mapping lost");
    chk_oc_gates_off:
    assert property (oc_evt |=> (gate_drive_ff == 6'h00) && overcurrent_ff && !fault_n_ff)
        else $error("overcurrent did not open the bridge");
    chk_blank_mask:
    assert property (s_ff.gate_drive[0] && !s_ff.gate_prev[0] |-> !oc_hit[0] ##1 !oc_hit[0])
        else $error("overcurrent seen inside blanking");
    chk_uv_coast:
    assert property (sys_uv |=> (gate_drive_ff == 6'h00) && !fault_n_ff && system_fault_ff)
        else $error("undervoltage did not disable outputs");
    chk_ov_disabled:
    assert property (!supply_overvoltage_protect_enable |=> !overvoltage_ff)
        else $error("overvoltage flagged while disabled");
    chk_zero_flag:
    assert property (!$past(rst) |->
        zero_demand_ff == ($past(demand_out_ff) == dcfs_pkg::DEMAND_ZERO))
        else $error("zero demand flag wrong");
    chk_lock_release:
    assert property ((s_ff.sup_st == dcfs_pkg::SUP_STALL_LOCK) && zero_dem |=>
        !lock_ff && (s_ff.attempts == 4'h0)) else $error("lock not released by zero demand");
    chk_no_hold_restart:
    assert property (stall_evt && stall_no_hold_select && !limit_hit && !oc_evt |=>
        s_ff.sup_st == dcfs_pkg::SUP_RUN) else $error("no-hold stall did not restart");
    chk_ot_coast:
    assert property (over_temp |=> (gate_drive_ff == 6'h00) ##1 (gate_drive_ff == 6'h00))
        else $error("overtemperature did not coast");
endmodule
`default_nettype wire

// file: sim/dcfs_bridge_model.sv
// Behavioural external bridge with drain comparators
`timescale 1ns/100ps
`default_nettype none
module dcfs_bridge_model (
    // Bridge side
    input wire logic [5:0] gate_drive,
    input wire logic short_en,
    // Comparator outputs
    output logic [5:0] drain_over
);
    // A shorted leg trips only while its switch is on, like a real fault
    assign drain_over = gate_drive & {6{short_en}};
endmodule
`default_nettype wire

// file: sim/tb_dcfs_top.sv
// Self-checking testbench for the demand curve and fault supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_dcfs_top;
    logic sys_clk = '0, rst = 1'h1, curve_enable = '0, bidir_enable = '0, curve_wr_en = '0;
    logic bemf_lock_enable = '0, startup_lock_enable = '0, ramp_end = '0, short_en = '0;
    logic stall_hold_long_select = '0, stall_no_hold_select = '0, over_temp = '0;
    logic overcurrent_recovery_mode = '0, overcurrent_no_hold_select = '0;
    logic charge_pump_uv = '0, low_side_reg_uv = '0, motor_supply_over = '0;
    logic supply_overvoltage_protect_enable = '0;
    logic [8:0] demand_in = '0, demand_out_ff, duty_ff;
    logic [1:0] control_mode = '0, stall_retry_select = 2'h3, drain_threshold_ff;
    logic [1:0] overcurrent_blank_time_select = '0, overcurrent_filter_time_select = '0;
    logic [1:0] drain_voltage_threshold_select = '0;
    logic [15:0] loop_range_max = 16'h03E8, setpoint_ff;
    logic [15:0] motor_constant_estimate = '0, motor_constant_limit = 16'h0100;
    logic [5:0] curve_wr_loc = '0, gate_cmd = '0, drain_over, gate_drive_ff;
    logic [17:0] curve_wr_data = '0;
    logic [7:0] phase_advance = '0, angle_error_limit = 8'h10;
    logic reverse_ff, fault_n_ff, stall_ff, lock_ff, overcurrent_ff, system_fault_ff;
    logic overvoltage_ff, overtemp_ff, zero_demand_ff;
    int err_total = 0, samples_checked = 0, seed = 54;
    dcfs_top #(.TICK_CYCLES(5)) dut_u (.*);
    dcfs_bridge_model bridge_u (.gate_drive(gate_drive_ff), .short_en(short_en),
        .drain_over(drain_over));
    // Free-running clock
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [5:0] l, input logic [17:0] d);
        curve_wr_en = 1'h1;
        curve_wr_loc = l;
        curve_wr_data = d;
        cyc(1);
    endtask
    // Closed loop scales the magnitude to the range maximum, truncated
    function automatic logic [15:0] exp_sp(input logic [8:0] d);
        return control_mode == 2'h0 ? 16'h0 : 16'((32'(d) * 32'(loop_range_max)) / 511);
    endfunction
    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog, about twice the expected run length
    initial
    begin
        #1000000;
        err_total++;
        end_sim();
    end
    // Main sequence
    initial
    begin
        cyc(10);
        rst = '0;
        cyc(1);
        chk("fault_n", 16'h1, fault_n_ff);
        repeat (24)
        begin
            demand_in = 9'($random(seed));
            control_mode = 2'($random(seed));
            loop_range_max = 16'($random(seed));
            cyc(4);
            chk("ident", demand_in, demand_out_ff);
            chk("zero", demand_in == 9'h0, zero_demand_ff);
            chk("duty", control_mode == 2'h0 ? demand_in : 9'h0, duty_ff);
            chk("setpt", exp_sp(demand_in), setpoint_ff);
        end
        $display("identity done");
        control_mode = '0;
        bidir_enable = 1'h1;
        demand_in = '0;
        cyc(4);
        chk("rev", 16'h1, reverse_ff);
        chk("duty", 16'h01FE, duty_ff);
        demand_in = 9'h0FF;
        cyc(4);
        chk("duty", 16'h0, duty_ff);
        bidir_enable = '0;
        // Corner after the end marker must be ignored
        wr(6'h20, {9'h064, 9'h032});
        wr(6'h21, {9'h1FF, 9'h1FF});
        wr(6'h22, 18'h0);
        curve_wr_en = '0;
        curve_enable = 1'h1;
        demand_in = 9'h12C;
        cyc(80);
        chk("curve", 16'h0112, demand_out_ff);
        demand_in = 9'h028;
        cyc(80);
        chk("curve", 16'h0032, demand_out_ff);
        // Descending corner makes a band at 80..100 with two outputs
        wr(6'h21, {9'h050, 9'h0C8});
        wr(6'h22, {9'h1FF, 9'h1FF});
        curve_wr_en = '0;
        demand_in = 9'h05A;
        cyc(80);
        chk("hyst", 16'h0032, demand_out_ff);
        demand_in = 9'h078;
        cyc(80);
        chk("curve", 16'h00E4, demand_out_ff);
        demand_in = 9'h05A;
        cyc(80);
        chk("hyst", 16'h00C8, demand_out_ff);
        curve_enable = '0;
        $display("curve done");
        demand_in = 9'h100;
        gate_cmd = 6'h01;
        short_en = 1'h1;
        cyc(60);
        chk("oc", 16'h1, overcurrent_ff);
        chk("gate", 16'h0, gate_drive_ff);
        short_en = '0;
        demand_in = '0;
        cyc(6);
        demand_in = 9'h100;
        cyc(4);
        chk("oc", 16'h0, overcurrent_ff);
        charge_pump_uv = 1'h1;
        cyc(3);
        chk("sysf", 16'h1, system_fault_ff);
        chk("gate", 16'h0, gate_drive_ff);
        charge_pump_uv = '0;
        motor_supply_over = 1'h1;
        cyc(3);
        chk("ov", 16'h0, overvoltage_ff);
        supply_overvoltage_protect_enable = 1'h1;
        cyc(3);
        chk("ov", 16'h1, overvoltage_ff);
        motor_supply_over = '0;
        over_temp = 1'h1;
        cyc(3);
        chk("ot", 16'h1, overtemp_ff);
        over_temp = '0;
        cyc(3);
        chk("ot", 16'h0, overtemp_ff);
        chk("gate", 16'h1, gate_drive_ff);
        $display("faults done");
        bemf_lock_enable = 1'h1;
        motor_constant_estimate = 16'h0200;
        cyc(1);
        motor_constant_estimate = '0;
        cyc(3);
        chk("stall", 16'h1, stall_ff);
        chk("gate", 16'h0, gate_drive_ff);
        // Short hold is 5000 ticks of 5 cycles each
        cyc(25010);
        chk("stall", 16'h0, stall_ff);
        chk("gate", 16'h1, gate_drive_ff);
        // Retry limit 3 without hold: repeated stalls end in lock
        stall_no_hold_select = 1'h1;
        stall_retry_select = '0;
        startup_lock_enable = 1'h1;
        ramp_end = 1'h1;
        phase_advance = 8'h20;
        cyc(6);
        chk("lock", 16'h1, lock_ff);
        chk("gate", 16'h0, gate_drive_ff);
        ramp_end = '0;
        demand_in = '0;
        cyc(4);
        chk("lock", 16'h0, lock_ff);
        $display("stall done");
        end_sim();
    end
endmodule
`default_nettype wire
